// ---- common/afe_consts.svh ----
// Offsets, field positions, reset values and timing counts of the control bank
`ifndef AFE_CONSTS_SVH
`define AFE_CONSTS_SVH

`define AFE_OFS_LINK_RX_CFG 8'h05
`define AFE_OFS_AMP_EN 8'h06
`define AFE_OFS_LED_LINK_EN 8'h07
`define AFE_OFS_SUPERVISOR 8'h08
`define AFE_OFS_PIN_MUX 8'h0B
`define AFE_OFS_CO_SW 8'h0C

`define AFE_RST_VALUE 8'h00

// Writable bits of each register; all others read zero
`define AFE_MASK_LINK_RX_CFG 8'h20
`define AFE_MASK_AMP_EN 8'h2D
`define AFE_MASK_LED_LINK_EN 8'h86
`define AFE_MASK_SUPERVISOR 8'h3C
`define AFE_MASK_PIN_MUX 8'hB7
`define AFE_MASK_CO_SW 8'hF0

`define AFE_BIT_RX_HYS 5
`define AFE_BIT_RX_EN 5
`define AFE_BIT_PHOTO_INPUT_AMP_ENABLE 3
`define AFE_BIT_PHOTO_GAIN_AMP_ENABLE 2
`define AFE_BIT_LEDREG_EN 0
`define AFE_BIT_LED_SEL 7
`define AFE_BIT_LED_GATE 2
`define AFE_BIT_TX_EN 1
`define AFE_BIT_HOST_DIS 5
`define AFE_BIT_BOR_DIS 4
`define AFE_BIT_SUPERR_DIS 3
`define AFE_BIT_OVERTEMP_FAULT_ENABLE 2
`define AFE_BIT_SOFT_RST 1
`define AFE_BIT_MUX_BYP 7
`define AFE_MSB_MUX_SRC 5
`define AFE_LSB_MUX_SRC 4
`define AFE_MSB_PIN_MODE 2
`define AFE_LSB_PIN_MODE 0
`define AFE_BIT_CO_RO 7
`define AFE_BIT_CO_RG 6
`define AFE_BIT_CO_RI 5
`define AFE_BIT_CO_REF 4

// Pin mode codes
`define AFE_PIN_HIZ 3'h0
`define AFE_PIN_ERR_OUT 3'h2
`define AFE_PIN_LED_A 3'h4
`define AFE_PIN_LED_B 3'h5

// Supply-low warning hold-off after the monitor is re-enabled
`define AFE_CLK_MHZ 25
`define AFE_BOR_MASK_US 1000
`define AFE_BOR_MASK_CYCLES (`AFE_BOR_MASK_US * `AFE_CLK_MHZ)

`endif

// ---- common/afe_pkg.sv ----
// Types shared by the control bank and its users
package afe_pkg;

	// Register access from the serial interface engine
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} afe_req_s;

	// Analog control levels driven from the bank
	typedef struct packed {
		logic link_rx_hysteresis_sel;
		logic link_rx_enable;
		logic link_tx_enable;
		logic photo_input_amp_enable;
		logic photo_gain_amp_enable;
		logic led_regulator_enable;
		logic host_supply_disable;
		logic brownout_monitor_disable;
		logic analog_mux_bypass;
		logic analog_mux_buffer_enable;
		logic [1:0] analog_mux_source;
		logic co_output_resistor_sw;
		logic co_feedback_resistor_sw;
		logic co_input_resistor_sw;
		logic co_reference_sw;
	} afe_ctrl_s;

	// Hold-off timer state, one-hot
	typedef enum logic [1:0] {
		AFE_BOR_IDLE = 2'b01,
		AFE_BOR_HOLD = 2'b10
	} afe_bor_e;

endpackage

// ---- logic/afe_ctrl_bank.sv ----
// Control and configuration register bank of the smoke and CO front end
`timescale 1ns/1ns
`include "afe_consts.svh"

// Overview of operation
// - Receiver config bit 5 picks link hysteresis: 0 wide, 1 narrow.
// - First enable bit 5 switches the alarm-link receiver on.
// - First enable bits 3 and 2 enable photo input and gain amplifiers.
// - First enable bit 0 enables the LED supply regulator.
// - Second enable bit 7 picks LED B enable input, else LED A; the pick drives no output.
// - Second enable bit 2 lets the LED enable pin enable the LED block.
// - Second enable bit 1 enables the alarm-link transmitter.
// - Control bit 5 set disables the host supply regulator.
// - Control bit 4 set disables the brown-out monitor.
// - Control bit 3 clear lets a supply power-good error enter fault mode.
// - Control bit 2 set lets over-temperature enter fault, raising flag.
// - Writing soft reset returns the bank to defaults; bit self-clears.
// - Mux buffer on when source nonzero, unless bypass switch chosen.
// - Mux source: off, CO output, photo output, photodiode output.
// - Pin mode 0 is high impedance; 1, 3, 6, 7 are reserved.
// - Pin mode 2 drives pin high on any unmasked error, else low.
// - Pin modes 4 and 5 OR the pin into LED A or LED B enable.
// - CO switch bit 7 adds the output series resistor.
// - CO switch bit 6 connects the gain-selected feedback resistor.
// - CO switch bit 5 adds the input series resistor.
// - CO switch bit 4 ties the positive input to the internal reference.
// - Supply-low warning held off 1 ms after the monitor is re-enabled.
module afe_ctrl_bank #(
	parameter int BOR_MASK_CYCLES = `AFE_BOR_MASK_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire afe_pkg::afe_req_s req,
	output logic [7:0] rdata,
	output logic rvalid,
	output afe_pkg::afe_ctrl_s ctrl,
	output logic soft_reset_pulse,
	input wire logic led_a_enable_input,
	input wire logic led_b_enable_input,
	input wire logic led_enable_pin,
	output logic led_block_enable,
	output logic led_a_on,
	output logic led_b_on,
	input wire logic mp_pin_in,
	output logic mp_pin_out,
	output logic mp_pin_oe,
	input wire logic unmasked_error,
	input wire logic supply_pg_error,
	input wire logic overtemp_event,
	input wire logic supply_low_raw,
	output logic supply_low_set,
	output logic fault_entry,
	output logic thermal_shutdown_set
);
	import afe_pkg::*;

	localparam int CW = $clog2(BOR_MASK_CYCLES + 1);

	logic [7:0] link_receiver_config;
	logic [7:0] amplifier_enable_bank;
	logic [7:0] led_link_enable_bank;
	logic [7:0] supervisor_control;
	logic [7:0] pin_mode_and_mux_select;
	logic [7:0] co_switch_config;
	logic soft_hit;
	logic [2:0] pin_mode;
	logic led_a_eff;
	logic led_b_eff;
	logic bor_dis_prev;
	afe_bor_e bor_state;
	logic [CW-1:0] bor_count;

	// Soft reset is a write strobe, never stored, so it reads back zero
	assign soft_hit = req.wr && req.addr == `AFE_OFS_SUPERVISOR
		&& req.wdata[`AFE_BIT_SOFT_RST];

	// Register writes; soft reset outranks the write that carries it
	always_ff @(posedge clk)
	begin
		if (sys_rst || soft_hit)
		begin
			link_receiver_config <= `AFE_RST_VALUE;
			amplifier_enable_bank <= `AFE_RST_VALUE;
			led_link_enable_bank <= `AFE_RST_VALUE;
			supervisor_control <= `AFE_RST_VALUE;
			pin_mode_and_mux_select <= `AFE_RST_VALUE;
			co_switch_config <= `AFE_RST_VALUE;
		end
		else if (req.wr)
		begin
			// Masking keeps reserved bits at zero
			case (req.addr)
				`AFE_OFS_LINK_RX_CFG:
					link_receiver_config <= req.wdata & `AFE_MASK_LINK_RX_CFG;
				`AFE_OFS_AMP_EN:
					amplifier_enable_bank <= req.wdata & `AFE_MASK_AMP_EN;
				`AFE_OFS_LED_LINK_EN:
					led_link_enable_bank <= req.wdata & `AFE_MASK_LED_LINK_EN;
				`AFE_OFS_SUPERVISOR:
					supervisor_control <= req.wdata & `AFE_MASK_SUPERVISOR;
				`AFE_OFS_PIN_MUX:
					pin_mode_and_mux_select <= req.wdata & `AFE_MASK_PIN_MUX;
				`AFE_OFS_CO_SW:
					co_switch_config <= req.wdata & `AFE_MASK_CO_SW;
				default:
					link_receiver_config <= link_receiver_config;
			endcase
		end
	end

	// Soft reset announced to registers held outside this bank
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			soft_reset_pulse <= 1'b0;
		else
			soft_reset_pulse <= soft_hit;
	end

	// Read port: one cycle latency, unmapped offsets read zero
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end
		else
		begin
			rvalid <= req.rd;
			case (req.addr)
				`AFE_OFS_LINK_RX_CFG: rdata <= link_receiver_config;
				`AFE_OFS_AMP_EN: rdata <= amplifier_enable_bank;
				`AFE_OFS_LED_LINK_EN: rdata <= led_link_enable_bank;
				`AFE_OFS_SUPERVISOR: rdata <= supervisor_control;
				`AFE_OFS_PIN_MUX: rdata <= pin_mode_and_mux_select;
				`AFE_OFS_CO_SW: rdata <= co_switch_config;
				default: rdata <= 8'h00;
			endcase
		end
	end

	// Analog control levels straight from the register flops
	always_comb
	begin
		ctrl.link_rx_hysteresis_sel =
			link_receiver_config[`AFE_BIT_RX_HYS];
		ctrl.link_rx_enable = amplifier_enable_bank[`AFE_BIT_RX_EN];
		ctrl.photo_input_amp_enable =
			amplifier_enable_bank[`AFE_BIT_PHOTO_INPUT_AMP_ENABLE];
		ctrl.photo_gain_amp_enable =
			amplifier_enable_bank[`AFE_BIT_PHOTO_GAIN_AMP_ENABLE];
		ctrl.led_regulator_enable =
			amplifier_enable_bank[`AFE_BIT_LEDREG_EN];
		ctrl.link_tx_enable = led_link_enable_bank[`AFE_BIT_TX_EN];
		ctrl.host_supply_disable =
			supervisor_control[`AFE_BIT_HOST_DIS];
		ctrl.brownout_monitor_disable =
			supervisor_control[`AFE_BIT_BOR_DIS];
		ctrl.analog_mux_source = pin_mode_and_mux_select[
			`AFE_MSB_MUX_SRC:`AFE_LSB_MUX_SRC];
		ctrl.analog_mux_bypass =
			pin_mode_and_mux_select[`AFE_BIT_MUX_BYP];
		// Buffer and bypass switch are never both on
		ctrl.analog_mux_buffer_enable = !ctrl.analog_mux_bypass
			&& ctrl.analog_mux_source != 2'h0;
		ctrl.co_output_resistor_sw = co_switch_config[`AFE_BIT_CO_RO];
		ctrl.co_feedback_resistor_sw =
			co_switch_config[`AFE_BIT_CO_RG];
		ctrl.co_input_resistor_sw = co_switch_config[`AFE_BIT_CO_RI];
		ctrl.co_reference_sw = co_switch_config[`AFE_BIT_CO_REF];
	end

	assign pin_mode =
		pin_mode_and_mux_select[`AFE_MSB_PIN_MODE:`AFE_LSB_PIN_MODE];

	// Multipurpose pin; reserved codes leave it released like code 0
	always_comb
	begin
		mp_pin_oe = 1'b0;
		mp_pin_out = 1'b0;
		case (pin_mode)
			`AFE_PIN_ERR_OUT:
			begin
				mp_pin_oe = 1'b1;
				mp_pin_out = unmasked_error;
			end
			default:
				mp_pin_oe = 1'b0;
		endcase
	end

	// LED enables; the pin only joins in its own mode
	assign led_a_eff = led_a_enable_input
		|| (pin_mode == `AFE_PIN_LED_A && mp_pin_in);
	assign led_b_eff = led_b_enable_input
		|| (pin_mode == `AFE_PIN_LED_B && mp_pin_in);
	assign led_a_on = led_a_eff;
	assign led_b_on = led_b_eff;

	// Pin gate decides whether the enable pin reaches the LED block
	assign led_block_enable = led_link_enable_bank[`AFE_BIT_LED_GATE]
		&& led_enable_pin;

	// Chosen input is decoded here but drives neither the LED block nor any output
	logic led_selected;
	assign led_selected = led_link_enable_bank[`AFE_BIT_LED_SEL]
		? led_b_eff : led_a_eff;

	// Fault entry and thermal flag as one-cycle events
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			fault_entry <= 1'b0;
			thermal_shutdown_set <= 1'b0;
		end
		else
		begin
			fault_entry <= (supply_pg_error
				&& !supervisor_control[`AFE_BIT_SUPERR_DIS])
				|| (overtemp_event
				&& supervisor_control[`AFE_BIT_OVERTEMP_FAULT_ENABLE]);
			thermal_shutdown_set <= overtemp_event
				&& supervisor_control[`AFE_BIT_OVERTEMP_FAULT_ENABLE];
		end
	end

	// Hold-off timer; a fresh re-enable restarts the full window
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			bor_dis_prev <= 1'b0;
			bor_state <= AFE_BOR_IDLE;
			bor_count <= '0;
		end
		else
		begin
			bor_dis_prev <= ctrl.brownout_monitor_disable;
			case (bor_state)
				AFE_BOR_IDLE:
					if (bor_dis_prev && !ctrl.brownout_monitor_disable)
					begin
						bor_state <= AFE_BOR_HOLD;
						bor_count <= CW'(BOR_MASK_CYCLES - 1);
					end
				AFE_BOR_HOLD:
					if (ctrl.brownout_monitor_disable)
						bor_state <= AFE_BOR_IDLE;
					else if (bor_count == '0)
						bor_state <= AFE_BOR_IDLE;
					else
						bor_count <= bor_count - CW'(1);
				default:
					bor_state <= AFE_BOR_IDLE;
			endcase
		end
	end

	// Warning only while monitoring and outside the hold-off window
	assign supply_low_set = supply_low_raw
		&& !ctrl.brownout_monitor_disable
		&& bor_state == AFE_BOR_IDLE
		&& !(bor_dis_prev && !ctrl.brownout_monitor_disable);

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_wr(logic [7:0] ofs);
		req.wr && req.addr == ofs && !soft_hit;
	endsequence

	sequence s_rd(logic [7:0] ofs);
		req.rd && req.addr == ofs;
	endsequence

	a_hys_write: assert property (s_wr(`AFE_OFS_LINK_RX_CFG) |=>
		ctrl.link_rx_hysteresis_sel == $past(req.wdata[5]))
		else $error("hysteresis select not taken from write");

	a_amp_enables: assert property (s_wr(`AFE_OFS_AMP_EN) |=>
		ctrl.link_rx_enable == $past(req.wdata[5])
		&& ctrl.photo_input_amp_enable == $past(req.wdata[3])
		&& ctrl.photo_gain_amp_enable == $past(req.wdata[2])
		&& ctrl.led_regulator_enable == $past(req.wdata[0]))
		else $error("first enable bank fields wrong");

	a_led_gate_pin: assert property (led_block_enable ==
		(led_link_enable_bank[2] && led_enable_pin))
		else $error("led block enable ignores gate");

	a_tx_write: assert property (s_wr(`AFE_OFS_LED_LINK_EN) |=>
		ctrl.link_tx_enable == $past(req.wdata[1]))
		else $error("transmitter enable not taken");

	a_super_write: assert property (s_wr(`AFE_OFS_SUPERVISOR) |=>
		ctrl.host_supply_disable == $past(req.wdata[5])
		&& ctrl.brownout_monitor_disable == $past(req.wdata[4]))
		else $error("supervisor bits not taken");

	a_supply_fault: assert property (supply_pg_error
		&& !supervisor_control[3] |=> fault_entry)
		else $error("supply error did not enter fault");

	a_ots_fault: assert property (overtemp_event ##0
		!supervisor_control[2] && !supply_pg_error |=> !fault_entry
		&& !thermal_shutdown_set)
		else $error("over-temperature fault while disabled");

	a_soft_reset: assert property (req.wr && req.addr == `AFE_OFS_SUPERVISOR
		&& req.wdata[1] |=> supervisor_control == 8'h00
		&& amplifier_enable_bank == 8'h00 && co_switch_config == 8'h00
		&& soft_reset_pulse ##1 !soft_reset_pulse)
		else $error("soft reset did not clear bank");

	a_mux_buffer: assert property (ctrl.analog_mux_buffer_enable |->
		!ctrl.analog_mux_bypass && ctrl.analog_mux_source != 2'h0)
		else $error("mux buffer on while bypassed or off");

	a_pin_error: assert property (pin_mode == `AFE_PIN_ERR_OUT |->
		mp_pin_oe && mp_pin_out == unmasked_error)
		else $error("error pin not driven");

	a_pin_release: assert property (pin_mode != `AFE_PIN_ERR_OUT
		|-> !mp_pin_oe)
		else $error("pin driven outside error mode");

	a_led_a_or: assert property (pin_mode == `AFE_PIN_LED_A && mp_pin_in
		|-> led_a_on)
		else $error("pin did not enable led a");

	a_bor_holdoff: assert property ($fell(ctrl.brownout_monitor_disable)
		|-> !supply_low_set [*8])
		else $error("supply low warned inside hold-off");

	a_reserved_read: assert property (s_rd(`AFE_OFS_LINK_RX_CFG) |=>
		(rdata & ~8'h20) == 8'h00)
		else $error("reserved bits read nonzero");

	// Selected LED input reaches no port; only this assertion looks at it
	a_led_select: assert property (led_link_enable_bank[7] |->
		led_selected == led_b_eff)
		else $error("led input select wrong");

endmodule // afe_ctrl_bank

// ---- sim/afe_host_model.sv ----
// Host-side model that issues register writes and reads to the bank
`timescale 1ns/1ns
module afe_host_model (
	input wire logic clk,
	output afe_pkg::afe_req_s req,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	import afe_pkg::*;

	// Idle request from time zero, so no strobe is seen during reset
	initial req = '0;

	// One write; strobe held until the edge that takes it, then dropped
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// One read; the answer stands for one cycle after the taking edge
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(posedge clk);
		req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		d = rdata;
		v = rvalid;
	endtask
endmodule // afe_host_model

// ---- sim/testbench.sv ----
// Self-checking testbench of the control register bank
`timescale 1ns/1ns
`include "afe_consts.svh"
module testbench;
	import afe_pkg::*;
	localparam int HOLD = 20;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	afe_req_s req;
	logic [7:0] rdata;
	logic rvalid;
	afe_ctrl_s ctrl;
	logic soft_reset_pulse;
	logic led_a_enable_input = 1'b0;
	logic led_b_enable_input = 1'b0;
	logic led_enable_pin = 1'b0;
	logic mp_pin_in = 1'b0;
	logic unmasked_error = 1'b0;
	logic supply_pg_error = 1'b0;
	logic overtemp_event = 1'b0;
	logic supply_low_raw = 1'b0;
	logic led_block_enable, led_a_on, led_b_on, mp_pin_out, mp_pin_oe;
	logic supply_low_set, fault_entry, thermal_shutdown_set;
	logic [7:0] sh [6] = '{default: 8'h00};
	logic [7:0] ofs [6] = '{`AFE_OFS_LINK_RX_CFG, `AFE_OFS_AMP_EN,
		`AFE_OFS_LED_LINK_EN, `AFE_OFS_SUPERVISOR, `AFE_OFS_PIN_MUX,
		`AFE_OFS_CO_SW};
	logic [7:0] msk [6] = '{`AFE_MASK_LINK_RX_CFG, `AFE_MASK_AMP_EN,
		`AFE_MASK_LED_LINK_EN, `AFE_MASK_SUPERVISOR, `AFE_MASK_PIN_MUX,
		`AFE_MASK_CO_SW};
	int fail_count = 0;
	int checked = 0;

	afe_ctrl_bank #(.BOR_MASK_CYCLES(HOLD)) afe_ctrl_bank_i (.clk, .sys_rst,
		.req, .rdata, .rvalid, .ctrl, .soft_reset_pulse, .led_a_enable_input,
		.led_b_enable_input, .led_enable_pin, .led_block_enable, .led_a_on,
		.led_b_on, .mp_pin_in, .mp_pin_out, .mp_pin_oe, .unmasked_error,
		.supply_pg_error, .overtemp_event, .supply_low_raw, .supply_low_set,
		.fault_entry, .thermal_shutdown_set);

	afe_host_model afe_host_model_i (.clk, .req, .rdata, .rvalid);

	// Free-running 25 MHz clock
	initial forever #20 clk = ~clk;

	// Control levels expected from the shadow copy, in struct field order
	function automatic afe_ctrl_s exp_ctrl();
		return {sh[0][5], sh[1][5], sh[2][1], sh[1][3], sh[1][2], sh[1][0],
			sh[3][5], sh[3][4], sh[4][7], !sh[4][7] && sh[4][5:4] != 2'h0,
			sh[4][5:4], sh[5][7:4]};
	endfunction

	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Write through the host and keep what the bank should hold
	task automatic wr(input int i, input logic [7:0] d);
		afe_host_model_i.wr_reg(ofs[i], d);
		sh[i] = d & msk[i];
	endtask

	task automatic rd_chk(input int i);
		logic [7:0] d;
		logic v;
		afe_host_model_i.rd_reg(ofs[i], d, v);
		chk("rvalid", 16'(v), 16'h0001);
		chk("rdata", 16'(d), 16'(sh[i]));
	endtask

	// Pulse one event input and look at the set pulses a cycle later
	task automatic pulse_ev(input logic ot, input logic fe, input logic ts);
		@(posedge clk);
		overtemp_event <= ot;
		supply_pg_error <= !ot;
		@(posedge clk);
		overtemp_event <= 1'b0;
		supply_pg_error <= 1'b0;
		#1;
		chk("fault_entry", 16'(fault_entry), 16'(fe));
		chk("thermal", 16'(thermal_shutdown_set), 16'(ts));
	endtask

	task automatic results();
		if (fail_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watchdog well beyond the expected run of a few hundred cycles
	initial
	begin
		#(40 * 20000);
		fail_count++;
		results();
	end

	// Main sequence
	initial
	begin
		int i;
		int m;
		logic [7:0] d;
		logic v;
		void'($urandom(32'hd132));
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 6; i++)
			rd_chk(i);
		chk("ctrl", ctrl, exp_ctrl());
		// Random traffic over all registers and two unmapped places, written at 09 and read at 0A
		repeat (40)
		begin
			i = $urandom % 7;
			d = 8'($urandom);
			if (i == 6)
			begin
				afe_host_model_i.wr_reg(8'h09, d);
				afe_host_model_i.rd_reg(8'h0A, d, v);
				chk("unmapped", 16'(d), 16'h0000);
			end
			else
			begin
				if (i == 3)
					d[1] = 1'b0;
				wr(i, d);
			end
			@(posedge clk);
			#1;
			chk("ctrl", ctrl, exp_ctrl());
			rd_chk($urandom % 6);
		end
		// Every pin mode code with random pin and LED inputs
		for (m = 0; m < 8; m++)
		begin
			wr(4, 8'(m));
			wr(2, 8'($urandom));
			repeat (4)
			begin
				@(posedge clk);
				{led_a_enable_input, led_b_enable_input, led_enable_pin,
					mp_pin_in, unmasked_error} <= 5'($urandom);
				@(posedge clk);
				#1;
				chk("pin_oe", 16'(mp_pin_oe), 16'(m == 2));
				if (m == 2)
					chk("pin_out", 16'(mp_pin_out), 16'(unmasked_error));
				chk("led_a", 16'(led_a_on), 16'(led_a_enable_input | (m == 4 && mp_pin_in)));
				chk("led_b", 16'(led_b_on), 16'(led_b_enable_input | (m == 5 && mp_pin_in)));
				chk("led_blk", 16'(led_block_enable), 16'(sh[2][2] & led_enable_pin));
			end
		end
		// Fault entry gates for both event kinds
		for (m = 0; m < 4; m++)
		begin
			wr(3, 8'(m << 2));
			pulse_ev(1'b0, !m[1], 1'b0);
			pulse_ev(1'b1, m[0], m[0]);
		end
		// Warning hold-off after the monitor is re-enabled
		wr(3, 8'h10);
		supply_low_raw <= 1'b1;
		wr(3, 8'h00);
		repeat (HOLD - 2)
		begin
			@(posedge clk);
			#1;
			chk("low_hold", 16'(supply_low_set), 16'h0000);
		end
		repeat (6) @(posedge clk);
		#1;
		chk("low_after", 16'(supply_low_set), 16'h0001);
		// Soft reset clears every register, reserved pin mode 7 included
		for (i = 0; i < 6; i++)
			wr(i, (i == 3) ? 8'h3C : 8'hFF);
		afe_host_model_i.wr_reg(`AFE_OFS_SUPERVISOR, 8'h3E);
		#1;
		chk("sr_pulse", 16'(soft_reset_pulse), 16'h0001);
		@(posedge clk);
		#1;
		chk("sr_pulse", 16'(soft_reset_pulse), 16'h0000);
		for (i = 0; i < 6; i++)
		begin
			sh[i] = 8'h00;
			rd_chk(i);
		end
		chk("ctrl", ctrl, exp_ctrl());
		results();
	end
endmodule // testbench
